// File: inc/accel_regs_pkg.sv
// Register offsets, field positions, reset values and carrier types of the output bank.
package accel_regs_pkg;
  localparam int SAMPLE_W = 14;
  localparam int FIFO_RES = 12;
  localparam int FIFO_DEPTH = 8;
  localparam logic [7:0] ADDR_STRAP_STATUS = 8'h00;
  localparam logic [7:0] DEVICE_CONDITION_STATUS = 8'h01;
  localparam logic [7:0] X_SAMPLE_LOW = 8'h02;
  localparam logic [7:0] Z_SAMPLE_HIGH = 8'h07;
  localparam logic [7:0] STRAP_RESET = 8'h00;
  localparam logic [7:0] COND_RESET = 8'h04;
  localparam logic [7:0] COND_RESV_VAL = 8'h04;
  localparam logic [15:0] AXIS_RESET = 16'h0000;
  localparam int STRAP_BIT = 3;
  localparam int OVERRUN_BIT = 0;
  localparam int CLKOFF_BIT = 1;
  localparam int NVM_BIT = 5;
  localparam int WATCH_BIT = 6;
  localparam int DETECT_BIT = 7;
  localparam logic [6:0] BASE_ADDR_LOW = 7'h4c;
  localparam logic [6:0] BASE_ADDR_HIGH = 7'h6c;
  localparam logic [2:0] MODE_CONT_WAKE = 3'b101;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int SYNC_STAGES = 3;

  typedef struct packed {
    logic [SAMPLE_W-1:0] z;
    logic [SAMPLE_W-1:0] y;
    logic [SAMPLE_W-1:0] x;
  } sample_t;

  typedef struct packed {
    logic clocks_off;
    logic nvm_supply_on;
    logic watch_active;
    logic watch_event;
    logic [2:0] mode_state;
  } condition_t;

  typedef struct packed {
    logic two_wire_port_enable;
    logic four_wire_port_enable;
    logic three_wire_port_enable;
  } port_enable_t;
endpackage

// File: logic/accel_status_output_regs.sv
// Status and axis output register bank with two-wire slave port and sample FIFO.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////

module sample_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic full_ff;
  logic in_ready_ff;
  logic empty_ff;
  logic push;
  logic pop;
  logic [AW:0] nxt_count;

  assign push = in_valid && !full_ff;
  assign pop = out_ready && !empty_ff;
  // Ready has its own flop so that the top-level ready output leaves a register.
  assign in_ready = in_ready_ff;
  assign out_valid = !empty_ff;
  assign out_data = mem[rd_ptr_ff];

  always_comb begin
    nxt_count = count_ff;
    if (push && !pop) begin
      nxt_count = count_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_count = count_ff - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
      full_ff <= 1'b0;
      empty_ff <= 1'b1;
      in_ready_ff <= 1'b1;
    end else if (ce) begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      count_ff <= nxt_count;
      full_ff <= (nxt_count == (AW + 1)'(DEPTH));
      in_ready_ff <= (nxt_count != (AW + 1)'(DEPTH));
      empty_ff <= (nxt_count == '0);
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////

module accel_status_output_regs #(
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_strap_pin,
  input wire accel_regs_pkg::port_enable_t port_enables,
  input wire logic fifo_enable,
  input wire accel_regs_pkg::condition_t condition,
  input wire logic sample_valid,
  input wire accel_regs_pkg::sample_t sample_data,
  output logic sample_ready,
  output logic cont_wake_req,
  output logic addr_select_bit
);
  import accel_regs_pkg::*;

  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_ADDR = 7'b0000010,
    S_AACK = 7'b0000100,
    S_WR = 7'b0001000,
    S_WACK = 7'b0010000,
    S_RD = 7'b0100000,
    S_RACK = 7'b1000000
  } slave_state_t;

  slave_state_t state_ff;
  logic [SYNC_STAGES-1:0] scl_sync_ff;
  logic [SYNC_STAGES-1:0] sda_sync_ff;
  logic scl_ff;
  logic sda_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic open_ff;
  logic strap_taken_ff;
  logic [3:0] bitcnt_ff;
  logic [7:0] shift_ff;
  logic [7:0] tx_ff;
  logic [7:0] ptr_ff;
  logic first_wr_ff;
  logic rw_ff;
  logic [7:0] cond_ff;
  logic detect_ff;
  logic burst_ff;
  logic advance_ff;
  logic unread_ff;
  logic loaded_ff;
  logic [15:0] axis_ff [3];
  logic [7:0] rd_byte;
  logic [6:0] own_addr;
  logic any_port;
  logic fifo_valid;
  logic take;
  sample_t fifo_data;

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling: three stages, a change is accepted once stages two and three agree.

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_ff <= '1;
      sda_sync_ff <= '1;
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
    end else if (ce) begin
      scl_sync_ff <= {scl_sync_ff[SYNC_STAGES-2:0], scl_pin};
      sda_sync_ff <= {sda_sync_ff[SYNC_STAGES-2:0], sda_in};
      if (scl_sync_ff[1] == scl_sync_ff[2]) begin
        scl_ff <= scl_sync_ff[2];
      end
      if (sda_sync_ff[1] == sda_sync_ff[2]) begin
        sda_ff <= sda_sync_ff[2];
      end
    end
  end

  assign scl_rise = ce && !scl_ff && (scl_sync_ff[1] == scl_sync_ff[2]) && scl_sync_ff[2];
  assign scl_fall = ce && scl_ff && (scl_sync_ff[1] == scl_sync_ff[2]) && !scl_sync_ff[2];
  assign start_cond = ce && scl_ff && sda_ff && (sda_sync_ff[1] == sda_sync_ff[2])
                      && !sda_sync_ff[2] && scl_sync_ff[2];
  assign stop_cond = ce && scl_ff && !sda_ff && (sda_sync_ff[1] == sda_sync_ff[2])
                     && sda_sync_ff[2] && scl_sync_ff[2];

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture after reset release and slave address choice.

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_taken_ff <= 1'b0;
      addr_select_bit <= 1'b0;
    end else if (ce && !strap_taken_ff) begin
      strap_taken_ff <= 1'b1;
      addr_select_bit <= addr_strap_pin;
    end
  end

  assign own_addr = addr_select_bit ? BASE_ADDR_HIGH : BASE_ADDR_LOW;

  ////////////////////////////////////////////////////////////////////////////
  // Transaction window: registers are frozen between start and stop.

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      open_ff <= 1'b0;
    end else if (start_cond) begin
      open_ff <= 1'b1;
    end else if (stop_cond) begin
      open_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux.

  always_comb begin
    rd_byte = 8'h00;
    if (ptr_ff == ADDR_STRAP_STATUS) begin
      rd_byte = STRAP_RESET;
      rd_byte[STRAP_BIT] = addr_select_bit;
    end else if (ptr_ff == DEVICE_CONDITION_STATUS) begin
      rd_byte = cond_ff;
    end else if (ptr_ff >= X_SAMPLE_LOW && ptr_ff <= Z_SAMPLE_HIGH) begin
      rd_byte = ptr_ff[0] ? axis_ff[ptr_ff[2:1] - 2'd1][15:8]
                          : axis_ff[ptr_ff[2:1] - 2'd1][7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-wire slave: data bits taken on SCL rise, driven after SCL fall.

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= S_IDLE;
      bitcnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      tx_ff <= 8'h00;
      ptr_ff <= 8'h00;
      rw_ff <= 1'b0;
      first_wr_ff <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else if (start_cond) begin
      state_ff <= S_ADDR;
      bitcnt_ff <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_cond) begin
      state_ff <= S_IDLE;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      unique case (state_ff)
        S_ADDR, S_WR, S_RD: begin
          shift_ff <= {shift_ff[6:0], sda_ff};
          bitcnt_ff <= bitcnt_ff + 4'h1;
        end
        S_RACK: begin
          rw_ff <= !sda_ff;
        end
        S_IDLE, S_AACK, S_WACK: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (state_ff)
        S_ADDR: begin
          if (bitcnt_ff == BITS_PER_BYTE) begin
            if (shift_ff[7:1] == own_addr) begin
              state_ff <= S_AACK;
              rw_ff <= shift_ff[0];
              first_wr_ff <= 1'b1;
              sda_oe <= 1'b1;
            end else begin
              state_ff <= S_IDLE;
            end
          end
        end
        S_AACK, S_RACK: begin
          bitcnt_ff <= 4'h0;
          if (state_ff == S_AACK && !rw_ff) begin
            state_ff <= S_WR;
            sda_oe <= 1'b0;
          end else if (rw_ff) begin
            state_ff <= S_RD;
            tx_ff <= rd_byte;
            sda_oe <= !rd_byte[7];
            ptr_ff <= ptr_ff + 8'h01;
          end else begin
            state_ff <= S_IDLE;
            sda_oe <= 1'b0;
          end
        end
        S_WR: begin
          if (bitcnt_ff == BITS_PER_BYTE) begin
            state_ff <= S_WACK;
            sda_oe <= 1'b1;
            if (first_wr_ff) begin
              ptr_ff <= shift_ff;
            end
            first_wr_ff <= 1'b0;
          end
        end
        S_WACK: begin
          state_ff <= S_WR;
          bitcnt_ff <= 4'h0;
          sda_oe <= 1'b0;
        end
        S_RD: begin
          if (bitcnt_ff == BITS_PER_BYTE) begin
            state_ff <= S_RACK;
            sda_oe <= 1'b0;
          end else begin
            sda_oe <= !tx_ff[3'd7 - bitcnt_ff[2:0]];
          end
        end
        S_IDLE: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // FIFO read sequence tracking: a read run from 0x02 to 0x07 advances the queue.

  assign any_port = |port_enables;
  assign take = ce && fifo_valid && any_port && !open_ff
                && (!fifo_enable || advance_ff || !loaded_ff);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_ff <= 1'b0;
      advance_ff <= 1'b0;
      unread_ff <= 1'b0;
    end else if (ce) begin
      if (scl_fall && rw_ff && (state_ff == S_AACK || state_ff == S_RACK)) begin
        if (ptr_ff >= X_SAMPLE_LOW && ptr_ff <= Z_SAMPLE_HIGH) begin
          unread_ff <= 1'b0;
        end
        if (ptr_ff == X_SAMPLE_LOW) begin
          burst_ff <= 1'b1;
        end else if (ptr_ff == Z_SAMPLE_HIGH && burst_ff) begin
          advance_ff <= 1'b1;
          burst_ff <= 1'b0;
        end
      end else if (take) begin
        advance_ff <= 1'b0;
        unread_ff <= 1'b1;
      end
    end
  end

  sample_fifo #(
    .WIDTH($bits(sample_t)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .in_data(sample_data),
    .out_valid(fifo_valid),
    .out_ready(take),
    .out_data(fifo_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Axis registers, one per axis.

  for (genvar a = 0; a < 3; a++) begin : g_axis
    logic [SAMPLE_W-1:0] raw;
    logic [FIFO_RES-1:0] coarse;
    assign raw = (a == 0) ? fifo_data.x : (a == 1) ? fifo_data.y : fifo_data.z;
    assign coarse = raw[SAMPLE_W-1 -: FIFO_RES];
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        axis_ff[a] <= AXIS_RESET;
      end else if (take) begin
        if (fifo_enable) begin
          axis_ff[a] <= {{(16 - FIFO_RES){coarse[FIFO_RES-1]}}, coarse};
        end else begin
          axis_ff[a] <= {{(16 - SAMPLE_W){raw[SAMPLE_W-1]}}, raw};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Condition register and wake request.

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loaded_ff <= 1'b0;
      detect_ff <= 1'b0;
      cont_wake_req <= 1'b0;
      cond_ff <= COND_RESET;
    end else if (ce) begin
      cont_wake_req <= condition.watch_event;
      if (condition.watch_event) begin
        detect_ff <= 1'b1;
      end else if (condition.watch_active) begin
        detect_ff <= 1'b0;
      end
      if (take) begin
        loaded_ff <= 1'b1;
      end
      if (!open_ff) begin
        cond_ff <= COND_RESV_VAL;
        cond_ff[OVERRUN_BIT] <= take ? (loaded_ff && unread_ff) : cond_ff[OVERRUN_BIT];
        cond_ff[CLKOFF_BIT] <= condition.clocks_off;
        cond_ff[NVM_BIT] <= condition.nvm_supply_on;
        cond_ff[WATCH_BIT] <= condition.watch_active
                              && (condition.mode_state != MODE_CONT_WAKE);
        cond_ff[DETECT_BIT] <= detect_ff || condition.watch_event;
      end
    end
  end
endmodule

// File: dv/host_master.sv
// Behavioural two-wire host controller that reads the register bank.
`timescale 1ns/10ps
module host_master (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic pull
);
  logic [6:0] dev;
  int extra;
  initial begin
    scl = 1'h1;
    pull = 1'h0;
    dev = 7'h4c;
    extra = 0;
  end
  ////////////////////////////////////////
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  // The low phase is longer than the high phase so that device data settles before the rise.
  task automatic xfer(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      w(2);
      pull = !d[i];
      w(3 + extra);
      scl = 1'h1;
      w(3);
      r[i] = sda;
      scl = 1'h0;
    end
  endtask
  task automatic start();
    w(2);
    pull = 1'h0;
    w(4);
    scl = 1'h1;
    w(4);
    pull = 1'h1;
    w(4);
    scl = 1'h0;
  endtask
  task automatic stop();
    w(2);
    pull = 1'h1;
    w(4);
    scl = 1'h1;
    w(4);
    pull = 1'h0;
    w(4);
  endtask
  task automatic rd_open(input logic [7:0] ptr, output logic ok);
    logic [8:0] r1, r2, r3;
    start();
    xfer({dev, 1'h0, 1'h1}, r1);
    xfer({ptr, 1'h1}, r2);
    start();
    xfer({dev, 1'h1, 1'h1}, r3);
    ok = !r1[0] && !r2[0] && !r3[0];
  endtask
  task automatic get(input logic last, output logic [7:0] b);
    logic [8:0] r;
    xfer({8'hff, last}, r);
    b = r[8:1];
  endtask
endmodule

// File: dv/accel_out_assertions.sv
// Port-level checker for the status and axis output bank.
`timescale 1ns/10ps
module accel_out_checker #(
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic scl_pin,
  input wire logic sda_oe,
  input wire logic addr_strap_pin,
  input wire accel_regs_pkg::condition_t condition,
  input wire logic sample_valid,
  input wire logic sample_ready,
  input wire logic cont_wake_req,
  input wire logic addr_select_bit
);
  import accel_regs_pkg::*;
  logic [1:0] cnt_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_ff <= 2'h0;
    else if (ce && cnt_ff != 2'h3) cnt_ff <= cnt_ff + 2'h1;
  end
  ////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_strap_value: assert property (cnt_ff == 2'h1 |-> addr_select_bit == $past(addr_strap_pin))
    else $error("strap not captured");
  a_strap_held: assert property (cnt_ff == 2'h3 |-> $stable(addr_select_bit))
    else $error("strap changed");
  a_wake_pulse: assert property (ce && condition.watch_event |=> cont_wake_req)
    else $error("no wake request");
  a_wake_cause: assert property (cont_wake_req |-> $past(condition.watch_event))
    else $error("wake without event");
  a_wake_single: assert property (cont_wake_req |=> !cont_wake_req || $past(condition.watch_event))
    else $error("wake too long");
  a_sda_quiet: assert property (scl_pin && $past(scl_pin, 2) |-> $stable(sda_oe))
    else $error("data moved while clock high");
  a_sda_after_fall: assert property ($changed(sda_oe) |-> !$past(scl_pin, 2))
    else $error("data moved too early");
  a_ready_fall: assert property ($fell(sample_ready) |-> $past(sample_valid))
    else $error("ready fell without a sample");
  c_wake: cover property (cont_wake_req);
  c_full: cover property ($fell(sample_ready));
  c_ack: cover property ($rose(sda_oe) && addr_select_bit);
endmodule

bind accel_status_output_regs accel_out_checker #(.DEPTH(DEPTH)) u_checker (
  .clk(clk), .rst_n(rst_n), .ce(ce), .scl_pin(scl_pin), .sda_oe(sda_oe),
  .addr_strap_pin(addr_strap_pin), .condition(condition), .sample_valid(sample_valid),
  .sample_ready(sample_ready), .cont_wake_req(cont_wake_req), .addr_select_bit(addr_select_bit)
);

// File: dv/accel_status_output_regs_bench.sv
// Self-checking bench for the status and axis output bank.
`timescale 1ns/10ps
module accel_status_output_regs_bench;
  import accel_regs_pkg::*;
  logic clk, rst_n, en, strap, fifo_en, valid, ready, wake, sel, sda_oe, sda_out, scl, pull, ok;
  port_enable_t pe;
  condition_t cond;
  sample_t smp, s;
  sample_t q [$];
  logic [7:0] exp [8];
  logic [7:0] b;
  int n_mismatch, compares;
  bit ovr, unread, det;
  wire sda = !(sda_oe || pull);
  accel_status_output_regs #(.DEPTH(FIFO_DEPTH)) DUT (.clk(clk), .rst_n(rst_n), .ce(en),
    .scl_pin(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_pin(strap),
    .port_enables(pe), .fifo_enable(fifo_en), .condition(cond), .sample_valid(valid),
    .sample_data(smp), .sample_ready(ready), .cont_wake_req(wake), .addr_select_bit(sel));
  host_master HOST (.clk(clk), .sda(sda), .scl(scl), .pull(pull));
  always #10 clk = !clk;
  ////////////////////////////////////////
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %0t byte got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %0t flag got %b exp %b", $time, g, e);
    end
  endtask
  task automatic results();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic sample_t rs();
    logic [63:0] v;
    v = {$urandom, $urandom};
    return v[41:0];
  endfunction
  function automatic logic [15:0] ext(input logic [13:0] v, input bit f);
    return f ? {{4{v[13]}}, v[13:2]} : {{2{v[13]}}, v};
  endfunction
  task automatic load(input sample_t t);
    {exp[3], exp[2]} = ext(t.x, fifo_en);
    {exp[5], exp[4]} = ext(t.y, fifo_en);
    {exp[7], exp[6]} = ext(t.z, fifo_en);
    ovr = unread;
    unread = 1;
  endtask
  task automatic setc();
    exp[1] = {det, cond.watch_active && cond.mode_state != MODE_CONT_WAKE,
      cond.nvm_supply_on, 2'h0, 1'h1, cond.clocks_off, ovr};
  endtask
  task automatic burst(input logic [7:0] p, input int k);
    HOST.rd_open(p, ok);
    chk1(ok, 1'h1);
    for (int i = 0; i < k; i++) begin
      HOST.get(i == k - 1, b);
      chk8(b, exp[p + i]);
    end
    HOST.stop();
    if (p + k > 2) unread = 0;
  endtask
  task automatic push(input sample_t t);
    @(negedge clk);
    smp = t;
    valid = 1'h1;
    @(negedge clk);
    valid = 1'h0;
    repeat (10) @(negedge clk);
  endtask
  ////////////////////////////////////////
  initial begin
    #1000000;
    n_mismatch++;
    results();
  end
  initial begin
    clk = 0;
    en = 1;
    rst_n = 0;
    strap = 1;
    fifo_en = 0;
    valid = 0;
    pe = '0;
    cond = '0;
    smp = '0;
    exp = '{default: 8'h00};
    exp[0] = 8'h08;
    exp[1] = COND_RESET;
    void'($urandom(32'hf627));
    repeat (20) @(negedge clk);
    rst_n = 1;
    repeat (6) @(negedge clk);
    chk1(sel, 1'h1);
    chk1(sda_out, 1'h0);
    en = 0;
    cond.watch_event = 1'h1;
    repeat (3) @(negedge clk);
    chk1(wake, 1'h0);
    cond.watch_event = 1'h0;
    en = 1;
    HOST.rd_open(8'h00, ok);
    chk1(ok, 1'h0);
    HOST.stop();
    HOST.dev = BASE_ADDR_HIGH;
    strap = 0;
    burst(8'h00, 8);
    push(rs());
    burst(8'h02, 6);
    pe.two_wire_port_enable = 1'h1;
    for (int i = 0; i < 3; i++) begin
      s = rs();
      push(s);
      load(s);
      if (i > 0) begin
        setc();
        burst(8'h01, 1);
        burst(8'h02, 6);
      end
    end
    for (int i = 0; i < 7; i++) begin
      @(negedge clk);
      cond = 7'($urandom);
      cond.watch_event = i == 5;
      if (i[0]) cond.mode_state = MODE_CONT_WAKE;
      if (i == 5) cond.watch_active = 1'h0;
      if (i == 6) cond.watch_active = 1'h1;
      det = cond.watch_event || (det && !cond.watch_active);
      @(negedge clk);
      chk1(wake, i == 5);
      cond.watch_event = 1'h0;
      repeat (4) @(negedge clk);
      setc();
      burst(8'h01, 1);
    end
    HOST.rd_open(8'h02, ok);
    HOST.get(1'h0, b);
    chk8(b, exp[2]);
    s = rs();
    push(s);
    for (int i = 3; i < 8; i++) begin
      HOST.get(i == 7, b);
      chk8(b, exp[i]);
    end
    HOST.stop();
    load(s);
    burst(8'h02, 6);
    @(negedge clk);
    rst_n = 0;
    fifo_en = 1;
    repeat (3) @(negedge clk);
    rst_n = 1;
    repeat (6) @(negedge clk);
    chk1(sel, 1'h0);
    HOST.dev = BASE_ADDR_LOW;
    valid = 1;
    for (int i = 0; i < 12; i++) begin
      s = rs();
      smp = s;
      if (ready) q.push_back(s);
      @(negedge clk);
    end
    valid = 0;
    chk1(ready, 1'h0);
    while (q.size() > 0) begin
      load(q.pop_front());
      if (q.size() == 4) burst(8'h02, 3);
      burst(8'h02, 6);
      repeat (8) @(negedge clk);
    end
    results();
  end
endmodule
